// *** include/rfl_pkg.sv ***
// Offsets, field positions, reset values and counts of the receive block
package rfl_pkg;
    // Register offsets
    localparam logic [7:0] ADR_CTRL   = 8'hC5;
    localparam logic [7:0] ADR_NCO_HI = 8'hC6;
    localparam logic [7:0] ADR_NCO_LO = 8'hC7;
    localparam logic [7:0] ADR_CRC    = 8'hC9;
    localparam logic [7:0] ADR_PAJ    = 8'hCA;
    localparam logic [7:0] ADR_PAC    = 8'hCB;
    localparam logic [7:0] ADR_OH1    = 8'hD2;
    localparam logic [7:0] ADR_OH2    = 8'hD3;
    localparam logic [7:0] ADR_OH3    = 8'hD4;
    localparam logic [7:0] ADR_OH4    = 8'hD5;
    localparam logic [7:0] ADR_FSW    = 8'hDD;
    localparam logic [7:0] ADR_FSWSB  = 8'hDE;
    localparam logic [7:0] ADR_FRCTL  = 8'hE0;
    localparam logic [7:0] ADR_FRSTAT = 8'hE1;
    // Reset values
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_NCO_HI = 8'h17;
    localparam logic [7:0] RST_NCO_LO = 8'h5A;
    localparam logic [7:0] RST_PAJ    = 8'h2C;
    localparam logic [7:0] RST_PAC    = 8'h15;
    localparam logic [7:0] RST_FSW    = 8'h00;
    localparam logic [7:0] RST_FSWSB  = 8'h00;
    localparam logic [7:0] RST_FRCTL  = 8'h00;
    localparam logic [7:0] RST_RO     = 8'h00;
    // Writable bits
    localparam logic [7:0] MASK_6BIT  = 8'h3F;
    localparam logic [7:0] MASK_FRCTL = 8'h42;
    // Loopback and timing control bits
    localparam int B_BYPASS   = 5;
    localparam int B_HLOOP    = 4;
    localparam int B_RLB      = 3;
    localparam int B_LLB_CLK  = 2;
    localparam int B_LLB      = 1;
    localparam int B_RCLK_DIS = 0;
    // Framer control and status bits
    localparam int B_AUTO_LOSS = 6;
    localparam int B_ERCNT_RST = 1;
    localparam int B_REACQ     = 0;
    localparam int B_SYNC      = 3;
    localparam int B_FSDET     = 2;
    // Counts
    localparam logic [7:0] CRC_MAX      = 8'hFF;
    localparam logic [1:0] GOOD_TO_SYNC = 2'h2;
    localparam logic [2:0] BAD_TO_LOSS  = 3'h5;
    localparam int         NCO_ACC_W    = 24;

    typedef enum logic {FR_HUNT, FR_SYNC} rfl_fr_state_t;
endpackage

// *** include/rfl_pll_if.sv ***
// Control and clock lines between the register block and its PLL
`timescale 1ns/10ps
interface rfl_pll_if;
    logic [5:0]  alpha;
    logic [5:0]  beta;
    logic [15:0] cw;
    logic        load;
    logic        phase_up;
    logic        phase_dn;
    logic        clk_out;
    modport ctrl (output alpha, beta, cw, load, phase_up, phase_dn,
                  input clk_out);
    modport nco  (input alpha, beta, cw, load, phase_up, phase_dn,
                  output clk_out);
endinterface

// *** verilog/rfl_nco.sv ***
// Digital PLL oscillator that makes the receive payload clock
`timescale 1ns/10ps
module rfl_nco
    import rfl_pkg::*;
#(
    parameter int ACC_W = NCO_ACC_W  // Phase accumulator width
)(
    input  wire logic ref_clk_i,     // System clock
    input  wire logic rst_i,         // Sync reset, high
    rfl_pll_if.nco    pll            // Control and clock out
);
    localparam logic [ACC_W-1:0] NOM = {2'b01, {(ACC_W-2){1'b0}}};

    logic [5:0]       div_cnt_reg;
    logic             tick;
    logic [15:0]      cw_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] step;
    logic             up_reg;
    logic             dn_reg;
    logic             clk_reg;

    // Beta sets the accumulator update rate
    assign tick = (div_cnt_reg >= pll.beta);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || tick) begin
            div_cnt_reg <= 6'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cw_reg <= {RST_NCO_HI, RST_NCO_LO};
        end else if (pll.load) begin
            cw_reg <= pll.cw;
        end
    end

    // Phase requests wait for the next update
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else begin
            up_reg <= pll.phase_up || (up_reg && !tick);
            dn_reg <= pll.phase_dn || (dn_reg && !tick);
        end
    end

    always_comb begin
        step = NOM + ACC_W'($signed(cw_reg));
        if (up_reg && !dn_reg) begin
            step = step + ACC_W'(pll.alpha);
        end else if (dn_reg && !up_reg) begin
            step = step - ACC_W'(pll.alpha);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc_reg <= '0;
            clk_reg <= 1'b0;
        end else begin
            if (tick) begin
                acc_reg <= acc_reg + step;
            end
            clk_reg <= acc_reg[ACC_W-1];
        end
    end

    assign pll.clk_out = clk_reg;

    cw_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pll.load |=> $stable(cw_reg))
        else $error("control word changed without high byte load");
    acc_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !tick |=> $stable(acc_reg))
        else $error("accumulator moved off the beta rate");
endmodule // rfl_nco

// *** verilog/rfl_rx_regs.sv ***
// Receive framer loopback, PLL control, CRC count and overhead registers
`timescale 1ns/10ps
//
// Behaviour
// - Bypass bit routes payload around framer; cleared keeps framer in path.
// - Framer loopback bit feeds framer output back to framer input.
// - Remote loopback sends receive data, sync and clock to transmit side.
// - Clock local loopback drives receive clock from transmit clock, not PLL.
// - Data local loopback drives receive data and sync from transmit side.
// - Receive clock disable bit stops driving the receive clock output.
// - Loopback and timing control reads zero after reset: all normal.
// - 16-bit signed control word moves to accumulator on high byte write.
// - Control word resets to high byte 17h and low byte 5Ah.
// - Six-bit phase adjustment alpha resets to 2Ch.
// - Six-bit division ratio beta resets to 15h.
// - Digital PLL makes receive clock from alpha, beta and control word.
// - CRC error counter increments per error, saturates at FFh, clears.
// - Overhead one holds channel bits 10,8,7,6,5,4,3,2.
// - Overhead two holds channel bits 19,18,16,15,14,13,12,11.
// - Overhead three holds indicator, bit 1, loss defect, bits 24 to 20.
// - Overhead four holds bit 17, segment defect, bit 9, anomaly, stuff.
// - Ten-bit sync pattern, head bit 7 first, tail bit 0 last.
// - Expected stuff bits in bits 5:2, bit 3 first; both reset zero.
// - Sync after two good frames; optional loss after five bad frames.
module rfl_rx_regs
    import rfl_pkg::*;
(
    input  wire logic        ref_clk_i,        // System clock
    input  wire logic        rst_i,            // Sync reset, high
    input  wire logic        wb_cyc_i,         // Bus cycle
    input  wire logic        wb_stb_i,         // Bus strobe
    input  wire logic        wb_we_i,          // Write enable
    input  wire logic [7:0]  wb_adr_i,         // Register offset
    input  wire logic [7:0]  wb_dat_i,         // Write data
    input  wire logic [0:0]  wb_sel_i,         // Byte select
    output logic      [7:0]  wb_dat_o,         // Read data
    output logic             wb_ack_o,         // Acknowledge
    input  wire logic        tx_serial_data_i, // Transmit data pin
    input  wire logic        tx_frame_sync_i,  // Transmit sync pin
    input  wire logic        tx_clock_i,       // Transmit clock pin
    output logic             rx_serial_data_o, // Receive data pin
    output logic             rx_frame_sync_o,  // Receive sync pin
    output logic             rx_clock_o,       // Receive clock pin
    output logic             rx_clock_oe_o,    // Receive clock enable
    input  wire logic        raw_data_i,       // Unframed line data
    input  wire logic        raw_sync_i,       // Unframed line sync
    input  wire logic        demap_data_i,     // Framer output data
    input  wire logic        demap_sync_i,     // Framer output sync
    output logic             framer_in_o,      // Framer input data
    output logic             tx_path_data_o,   // To transmit data
    output logic             tx_path_sync_o,   // To transmit sync
    output logic             tx_path_clock_o,  // To transmit clock
    input  wire logic        frame_done_i,     // Frame end pulse
    input  wire logic [9:0]  rx_sync_word_i,   // Received sync word
    input  wire logic [3:0]  rx_stuff_i,       // Stuff bits, 3 first
    input  wire logic [24:1] rx_eoc_i,         // Channel bits 24..1
    input  wire logic        rx_uib_i,         // Unspecified bit
    input  wire logic        rx_losd_i,        // Loss of signal
    input  wire logic        rx_segd_i,        // Segment defect
    input  wire logic        rx_sega_i,        // Segment anomaly
    input  wire logic        crc_error_i,      // CRC error pulse
    input  wire logic        phase_early_i,    // Slow clock down
    input  wire logic        phase_late_i,     // Speed clock up
    output logic             frame_sync_o      // Framer in sync
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Link pins, two-flop synchronisers
    logic [2:0] link_meta_reg;
    logic [2:0] link_sync_reg;
    logic       tx_ser_s;
    logic       tx_fs_s;
    logic       tx_clk_s;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            link_meta_reg <= 3'h0;
            link_sync_reg <= 3'h0;
        end else begin
            link_meta_reg <= {tx_clock_i, tx_frame_sync_i,
                              tx_serial_data_i};
            link_sync_reg <= link_meta_reg;
        end
    end

    assign tx_ser_s = link_sync_reg[0];
    assign tx_fs_s  = link_sync_reg[1];
    assign tx_clk_s = link_sync_reg[2];

    // Bus slave
    logic wb_req;
    logic wb_new;
    logic wr_en;
    logic ack_reg;
    logic [7:0] rd_data;
    logic [7:0] dat_reg;

    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_new = wb_req && !ack_reg;
    assign wr_en  = wb_new && wb_we_i && wb_sel_i[0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_new;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dat_reg <= 8'h00;
        end else if (wb_new && !wb_we_i) begin
            dat_reg <= rd_data;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Software registers
    logic [7:0] ctrl_reg;
    logic [7:0] nco_hi_reg;
    logic [7:0] nco_lo_reg;
    logic [7:0] paj_reg;
    logic [7:0] pac_reg;
    logic [7:0] fsw_reg;
    logic [7:0] fswsb_reg;
    logic [7:0] frctl_reg;
    logic       reacq_reg;
    logic       nco_load_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= RST_CTRL;
        end else if (wr_en && wb_adr_i == ADR_CTRL) begin
            ctrl_reg <= wb_dat_i & MASK_6BIT;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nco_hi_reg   <= RST_NCO_HI;
            nco_lo_reg   <= RST_NCO_LO;
            nco_load_reg <= 1'b0;
        end else begin
            nco_load_reg <= wr_en && wb_adr_i == ADR_NCO_HI;
            if (wr_en && wb_adr_i == ADR_NCO_HI) begin
                nco_hi_reg <= wb_dat_i;
            end
            if (wr_en && wb_adr_i == ADR_NCO_LO) begin
                nco_lo_reg <= wb_dat_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            paj_reg <= RST_PAJ;
            pac_reg <= RST_PAC;
        end else begin
            if (wr_en && wb_adr_i == ADR_PAJ) begin
                paj_reg <= wb_dat_i & MASK_6BIT;
            end
            if (wr_en && wb_adr_i == ADR_PAC) begin
                pac_reg <= wb_dat_i & MASK_6BIT;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fsw_reg   <= RST_FSW;
            fswsb_reg <= RST_FSWSB;
        end else begin
            if (wr_en && wb_adr_i == ADR_FSW) begin
                fsw_reg <= wb_dat_i;
            end
            if (wr_en && wb_adr_i == ADR_FSWSB) begin
                fswsb_reg <= wb_dat_i & MASK_6BIT;
            end
        end
    end

    // Reacquire is a pulse, not stored
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            frctl_reg <= RST_FRCTL;
            reacq_reg <= 1'b0;
        end else begin
            reacq_reg <= wr_en && wb_adr_i == ADR_FRCTL
                         && wb_dat_i[B_REACQ];
            if (wr_en && wb_adr_i == ADR_FRCTL) begin
                frctl_reg <= wb_dat_i & MASK_FRCTL;
            end
        end
    end

    // Digital PLL
    rfl_pll_if pll_bus ();

    assign pll_bus.alpha    = paj_reg[5:0];
    assign pll_bus.beta     = pac_reg[5:0];
    assign pll_bus.cw       = {nco_hi_reg, nco_lo_reg};
    assign pll_bus.load     = nco_load_reg;
    assign pll_bus.phase_up = phase_late_i;
    assign pll_bus.phase_dn = phase_early_i;

    rfl_nco #(
        .ACC_W     (NCO_ACC_W)
    ) u_nco (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pll       (pll_bus.nco)
    );

    // Frame alignment
    logic          frame_good;
    rfl_fr_state_t fr_state_reg;
    logic [1:0]    good_cnt_reg;
    logic [2:0]    bad_cnt_reg;
    logic          fsdet_reg;

    assign frame_good = (rx_sync_word_i == {fsw_reg, fswsb_reg[1:0]})
                        && (rx_stuff_i == fswsb_reg[5:2]);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || reacq_reg) begin
            fr_state_reg <= FR_HUNT;
        end else if (frame_done_i) begin
            unique case (fr_state_reg)
                FR_HUNT: begin
                    if (frame_good
                        && good_cnt_reg == GOOD_TO_SYNC - 2'h1) begin
                        fr_state_reg <= FR_SYNC;
                    end
                end
                FR_SYNC: begin
                    if (!frame_good && frctl_reg[B_AUTO_LOSS]
                        && bad_cnt_reg >= BAD_TO_LOSS - 3'h1) begin
                        fr_state_reg <= FR_HUNT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || reacq_reg) begin
            good_cnt_reg <= 2'h0;
            bad_cnt_reg  <= 3'h0;
        end else if (frame_done_i) begin
            if (fr_state_reg == FR_HUNT && frame_good) begin
                good_cnt_reg <= good_cnt_reg + 2'h1;
            end else begin
                good_cnt_reg <= 2'h0;
            end
            if (fr_state_reg == FR_HUNT || frame_good) begin
                bad_cnt_reg <= 3'h0;
            end else if (bad_cnt_reg != BAD_TO_LOSS) begin
                bad_cnt_reg <= bad_cnt_reg + 3'h1;
            end
        end
    end

    assign frame_sync_o = (fr_state_reg == FR_SYNC);

    // CRC error count; an error beats a clear
    logic [7:0] crc_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            crc_reg <= RST_RO;
        end else if (crc_error_i) begin
            if (frctl_reg[B_ERCNT_RST]) begin
                crc_reg <= 8'h01;
            end else if (crc_reg != CRC_MAX) begin
                crc_reg <= crc_reg + 8'h01;
            end
        end else if (frctl_reg[B_ERCNT_RST]) begin
            crc_reg <= RST_RO;
        end
    end

    // Overhead capture, once per frame
    logic [7:0] oh1_reg;
    logic [7:0] oh2_reg;
    logic [7:0] oh3_reg;
    logic [7:0] oh4_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oh1_reg   <= RST_RO;
            oh2_reg   <= RST_RO;
            oh3_reg   <= RST_RO;
            oh4_reg   <= RST_RO;
            fsdet_reg <= 1'b0;
        end else if (frame_done_i) begin
            oh1_reg   <= {rx_eoc_i[10], rx_eoc_i[8:2]};
            oh2_reg   <= {rx_eoc_i[19:18], rx_eoc_i[16:11]};
            oh3_reg   <= {rx_uib_i, rx_eoc_i[1], rx_losd_i,
                          rx_eoc_i[24:20]};
            oh4_reg   <= {rx_eoc_i[17], rx_segd_i, rx_eoc_i[9],
                          rx_sega_i, rx_stuff_i};
            fsdet_reg <= frame_good;
        end
    end

    always_comb begin
        case (wb_adr_i)
            ADR_CTRL:   rd_data = ctrl_reg;
            ADR_NCO_HI: rd_data = nco_hi_reg;
            ADR_NCO_LO: rd_data = nco_lo_reg;
            ADR_CRC:    rd_data = crc_reg;
            ADR_PAJ:    rd_data = paj_reg;
            ADR_PAC:    rd_data = pac_reg;
            ADR_OH1:    rd_data = oh1_reg;
            ADR_OH2:    rd_data = oh2_reg;
            ADR_OH3:    rd_data = oh3_reg;
            ADR_OH4:    rd_data = oh4_reg;
            ADR_FSW:    rd_data = fsw_reg;
            ADR_FSWSB:  rd_data = fswsb_reg;
            ADR_FRCTL:  rd_data = frctl_reg;
            ADR_FRSTAT: rd_data = {4'h0, frame_sync_o, fsdet_reg, 2'h0};
            default:    rd_data = 8'h00;
        endcase
    end

    // Payload steering and loopbacks
    logic path_data;
    logic path_sync;
    logic rx_data_next;
    logic rx_sync_next;
    logic clk_src;
    logic rx_clk_next;

    assign path_data    = ctrl_reg[B_BYPASS] ? raw_data_i
                                             : demap_data_i;
    assign path_sync    = ctrl_reg[B_BYPASS] ? raw_sync_i
                                             : demap_sync_i;
    assign rx_data_next = ctrl_reg[B_LLB] ? tx_ser_s : path_data;
    assign rx_sync_next = ctrl_reg[B_LLB] ? tx_fs_s : path_sync;
    assign clk_src      = ctrl_reg[B_LLB_CLK] ? tx_clk_s
                                              : pll_bus.clk_out;
    assign rx_clk_next  = clk_src && !ctrl_reg[B_RCLK_DIS];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_serial_data_o <= 1'b0;
            rx_frame_sync_o  <= 1'b0;
            rx_clock_o       <= 1'b0;
            rx_clock_oe_o    <= 1'b0;
            framer_in_o      <= 1'b0;
        end else begin
            rx_serial_data_o <= rx_data_next;
            rx_frame_sync_o  <= rx_sync_next;
            rx_clock_o       <= rx_clk_next;
            rx_clock_oe_o    <= !ctrl_reg[B_RCLK_DIS];
            framer_in_o      <= ctrl_reg[B_HLOOP] ? demap_data_i
                                                  : raw_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_path_data_o  <= 1'b0;
            tx_path_sync_o  <= 1'b0;
            tx_path_clock_o <= 1'b0;
        end else if (ctrl_reg[B_RLB]) begin
            tx_path_data_o  <= rx_data_next;
            tx_path_sync_o  <= rx_sync_next;
            tx_path_clock_o <= clk_src;
        end else begin
            tx_path_data_o  <= tx_ser_s;
            tx_path_sync_o  <= tx_fs_s;
            tx_path_clock_o <= tx_clk_s;
        end
    end

    sequence s_good_frame;
        frame_done_i && frame_good && !reacq_reg;
    endsequence
    sequence s_bad_frame;
        frame_done_i && !frame_good && !reacq_reg;
    endsequence

    bypass_path_a: assert property (
        ctrl_reg[B_BYPASS] && !ctrl_reg[B_LLB]
        |=> rx_serial_data_o == $past(raw_data_i))
        else $error("bypass did not route raw data");
    framer_loop_a: assert property (
        ctrl_reg[B_HLOOP] |=> framer_in_o == $past(demap_data_i))
        else $error("framer loopback not applied");
    remote_loop_a: assert property (
        ctrl_reg[B_RLB] |=> tx_path_data_o == rx_serial_data_o
        && tx_path_sync_o == rx_frame_sync_o)
        else $error("remote loopback mismatch");
    clock_loop_a: assert property (
        ctrl_reg[B_LLB_CLK] && !ctrl_reg[B_RCLK_DIS]
        |=> rx_clock_o == $past(tx_clk_s))
        else $error("clock loopback not from transmit clock");
    local_loop_a: assert property (
        ctrl_reg[B_LLB] |=> rx_frame_sync_o == $past(tx_fs_s)
        && rx_serial_data_o == $past(tx_ser_s))
        else $error("data loopback not from transmit side");
    clock_off_a: assert property (
        ctrl_reg[B_RCLK_DIS] |=> !rx_clock_oe_o && !rx_clock_o)
        else $error("receive clock driven while disabled");
    ctrl_reset_a: assert property (
        $fell(rst_i) |-> ctrl_reg == RST_CTRL && !rx_clock_o)
        else $error("control not clear after reset");
    word_load_a: assert property (
        wr_en && wb_adr_i == ADR_NCO_HI |=> pll_bus.load)
        else $error("high byte write did not load word");
    crc_sat_a: assert property (
        crc_reg == CRC_MAX && !frctl_reg[B_ERCNT_RST]
        |=> crc_reg == CRC_MAX)
        else $error("error counter wrapped");
    sync_gain_a: assert property (
        fr_state_reg == FR_HUNT && good_cnt_reg == GOOD_TO_SYNC - 2'h1
        ##0 s_good_frame |=> frame_sync_o)
        else $error("sync not declared after two good frames");
    sync_loss_a: assert property (
        frame_sync_o && frctl_reg[B_AUTO_LOSS] && bad_cnt_reg == 3'h4
        ##0 s_bad_frame |=> !frame_sync_o)
        else $error("sync kept after five bad frames");
    oh_hold_a: assert property (
        !frame_done_i |=> $stable(oh1_reg) && $stable(oh4_reg))
        else $error("overhead changed between frames");
endmodule // rfl_rx_regs

// *** bench/rfl_framer_model.sv ***
// Transmit-side framer model driving the link pins
`timescale 1ns/10ps
module rfl_framer_model (
    output logic tx_data_o, // Transmit data
    output logic tx_sync_o, // Transmit sync
    output logic tx_clk_o   // Free-running link clock
);
    logic [7:0] bit_cnt;
    initial begin
        {tx_data_o, tx_sync_o, tx_clk_o, bit_cnt} = '0;
        forever begin
            #400 tx_clk_o = ~tx_clk_o;
            // Data moves on the falling link edge
            if (!tx_clk_o) begin
                bit_cnt = bit_cnt + 8'h01;
                tx_data_o = bit_cnt[0] ^ bit_cnt[2];
                tx_sync_o = (bit_cnt == 8'h00);
            end
        end
    end
endmodule // rfl_framer_model

// *** bench/tb_top.sv ***
// Self-checking bench for the receive register block
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    bad_count++; $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    import rfl_pkg::*;
    logic        ref_clk_i, rst_i, cyc, stb, we, ack, raw, fdone, crc;
    logic        tsd, tfs, tck, rsd, oe, rck, tpd, fin;
    logic [7:0]  adr, dat, q, dout;
    logic [7:0]  e [4];
    logic [41:0] fr;
    int          bad_count, samples_checked;
    logic [7:0]  ra [8] = '{ADR_CTRL, ADR_NCO_HI, ADR_NCO_LO, ADR_CRC,
                            ADR_PAJ, ADR_PAC, ADR_FSW, ADR_FSWSB};
    logic [7:0]  rv [8] = '{8'h00, 8'h17, 8'h5A, 8'h00,
                            8'h2C, 8'h15, 8'h00, 8'h00};
    rfl_framer_model rfl_framer_model_inst (.tx_data_o(tsd),
        .tx_sync_o(tfs), .tx_clk_o(tck));
    rfl_rx_regs rfl_rx_regs_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(1'b1), .wb_dat_o(dout), .wb_ack_o(ack),
        .tx_serial_data_i(tsd), .tx_frame_sync_i(tfs), .tx_clock_i(tck),
        .rx_serial_data_o(rsd), .rx_frame_sync_o(), .rx_clock_o(rck),
        .rx_clock_oe_o(oe), .raw_data_i(raw), .raw_sync_i(raw),
        .demap_data_i(~raw), .demap_sync_i(1'b0), .framer_in_o(fin),
        .tx_path_data_o(tpd), .tx_path_sync_o(), .tx_path_clock_o(),
        .frame_done_i(fdone), .rx_sync_word_i(fr[41:32]),
        .rx_stuff_i(fr[31:28]), .rx_eoc_i(fr[23:0]), .rx_uib_i(fr[27]),
        .rx_losd_i(fr[26]), .rx_segd_i(fr[25]), .rx_sega_i(fr[24]),
        .crc_error_i(crc), .phase_early_i(1'b0), .phase_late_i(1'b0),
        .frame_sync_o());
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) bad_count++;
        q = dout;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            crc <= 1'b1;
            @(posedge ref_clk_i);
            crc <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    task automatic frame(input int n);
        repeat (n) begin
            fdone <= 1'b1;
            @(posedge ref_clk_i);
            fdone <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    task print_verdict;
        $display("checked %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #5000000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {rst_i, cyc, stb, we, raw, fdone, crc} = 7'h40;
        {adr, dat} = '0;
        fr = 42'h2A5C396E1F0;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, ra[i], 8'h00);
            `CHK(q, rv[i])
        end
        wb(1'b0, 8'h80, 8'h00);
        `CHK(q, 8'h00)
        wb(1'b1, ADR_PAJ, 8'h3F);
        wb(1'b0, ADR_PAJ, 8'h00);
        `CHK(q, 8'h3F)
        wb(1'b1, ADR_NCO_LO, 8'h5B);
        wb(1'b1, ADR_NCO_HI, 8'h18);
        wb(1'b0, ADR_NCO_HI, 8'h00);
        `CHK(q, 8'h18)
        $display("test reset and access done");
        for (int b = 0; b < 2; b++) begin
            wb(1'b1, ADR_CTRL, {2'h0, b[0], 5'h00});
            raw <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            `CHK(rsd, b[0])
        end
        wb(1'b1, ADR_CTRL, 8'h10);
        `CHK(fin, ~raw)
        wb(1'b1, ADR_CTRL, 8'h0E);
        @(posedge tck);
        repeat (4) @(posedge ref_clk_i);
        `CHK(rsd, tsd)
        `CHK(rck, tck)
        `CHK(tpd, rsd)
        wb(1'b1, ADR_CTRL, 8'h01);
        `CHK(oe, 1'b0)
        wb(1'b1, ADR_CTRL, 8'h00);
        `CHK(oe, 1'b1)
        $display("test loopback done");
        pulse(3);
        wb(1'b1, ADR_CRC, 8'h55);
        wb(1'b0, ADR_CRC, 8'h00);
        `CHK(q, 8'h03)
        pulse(260);
        wb(1'b0, ADR_CRC, 8'h00);
        `CHK(q, 8'hFF)
        wb(1'b1, ADR_FRCTL, 8'h02);
        wb(1'b1, ADR_FRCTL, 8'h00);
        wb(1'b0, ADR_CRC, 8'h00);
        `CHK(q, 8'h00)
        $display("test crc count done");
        frame(1);
        e = '{{fr[9], fr[7:1]}, {fr[18:17], fr[15:10]},
              {fr[27], fr[0], fr[26], fr[23:19]},
              {fr[16], fr[25], fr[8], fr[24], fr[31:28]}};
        fr <= ~fr;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, ADR_OH1 + 8'(i), 8'h00);
            `CHK(q, e[i])
        end
        $display("test overhead done");
        wb(1'b1, ADR_FSW, fr[41:34]);
        wb(1'b1, ADR_FSWSB, {2'h0, fr[31:28], fr[33:32]});
        frame(2);
        wb(1'b0, ADR_FRSTAT, 8'h00);
        `CHK(q, 8'h0C)
        wb(1'b1, ADR_FRCTL, 8'h40);
        fr <= ~fr;
        frame(4);
        wb(1'b0, ADR_FRSTAT, 8'h00);
        `CHK(q, 8'h08)
        frame(1);
        wb(1'b0, ADR_FRSTAT, 8'h00);
        `CHK(q, 8'h00)
        $display("test frame sync done");
        print_verdict;
    end
endmodule // tb_top
